// ==== logic/hpc_pkg.sv ====
// package for the dual slot hot-plug power controller
package hpc_pkg;
	// timing
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned POR_TIME_US   = 250;
	localparam int unsigned POR_CYCLES    = (POR_TIME_US * (CLK_HZ / 1_000_000));
	localparam int unsigned DUR_TIME_US   = 5000;
	localparam int unsigned DUR_CYCLES    = (DUR_TIME_US * (CLK_HZ / 1_000_000));
	localparam int unsigned CNT_W         = 16;

	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL_A     = 8'h00;
	localparam logic [7:0] REG_CTRL_B     = 8'h04;
	localparam logic [7:0] REG_STAT_A     = 8'h08;
	localparam logic [7:0] REG_STAT_B     = 8'h0c;
	localparam logic [7:0] REG_COMMON     = 8'h10;

	// control fields
	localparam int unsigned CTL_MAIN_BIT  = 0;
	localparam int unsigned CTL_AUX_BIT   = 1;
	// status fault fields
	localparam int unsigned ST_OC_MAIN    = 0;
	localparam int unsigned ST_OC_AUX     = 1;
	localparam int unsigned ST_OT         = 2;
	localparam int unsigned ST_UV         = 3;
	localparam int unsigned ST_W          = 4;
	// common register fields
	localparam int unsigned CM_INT_EN     = 0;
	localparam int unsigned CM_BUS_CTRL   = 1;
	localparam int unsigned CM_GPI_LSB    = 2;
	localparam int unsigned CM_STBY       = 4;

	localparam logic [7:0] CTRL_RST       = 8'h00;

	typedef enum logic [1:0]
	{
		HPC_OFF     = 2'b00,
		HPC_ON      = 2'b01,
		HPC_REG     = 2'b11,
		HPC_TRIPPED = 2'b10
	} hpc_main_st_t;

	// analog status inputs per slot
	typedef struct packed
	{
		logic uv_main;
		logic ot;
		logic oc_main;
		logic woc_main;
		logic oc_aux;
		logic out_ok;
	} hpc_sense_t;

	typedef struct packed
	{
		hpc_main_st_t       main_st;
		logic               aux_on;
		logic               aux_tripped;
		logic [CNT_W-1:0]   main_dur;
		logic [CNT_W-1:0]   aux_dur;
		logic [ST_W-1:0]    fault;
		logic [7:0]         ctrl;
		logic               main_en_q;
		logic               aux_en_q;
	} hpc_slot_t;
endpackage : hpc_pkg

// ==== logic/hpc_top.sv ====
// dual slot hot-plug power sequencing logic with register port
`timescale 1ns/1ps
//
// Summary of operation
// RULE_01 - por completes after 250 us valid standby
// RULE_02 - por clears all internal registers
// RULE_03 - standby dropout restarts power-on reset
// RULE_04 - outputs off, bus blocked during por
// RULE_05 - fault low on oc, ot, uv
// RULE_06 - fault released when enable deasserted
// RULE_07 - severe overcurrent trips main immediately
// RULE_08 - duration timeout trips main or aux
// RULE_09 - host uses only one control interface
// RULE_10 - non-power registers stay accessible under pins
// RULE_11 - bus reports faults and input pins
// RULE_12 - aux enable turns aux switch on
// RULE_13 - standby when main supply absent or low
// RULE_14 - aux independent of main, works in standby
// RULE_15 - main enabled entering standby raises fault
// RULE_16 - main undervoltage raises interrupt if enabled
// RULE_17 - gates idle high/low, driven when enabled
// RULE_18 - block under lockout, power-good on outputs
// RULE_19 - bus inactive when strapped disabled
// RULE_20 - writing one to fault bit clears interrupt
// RULE_21 - changing control enable bits clears fault
// RULE_22 - per-slot logic replicated, shared bus, interrupt
module hpc_top
	import hpc_pkg::*;
#(
	parameter int unsigned POR_CNT = POR_CYCLES,
	parameter int unsigned DUR_CNT = DUR_CYCLES
)
(
	input  wire logic             ref_clk_i,
	input  wire logic             srst_i,
	input  wire logic             stby_valid_i,
	input  wire logic             mains_present_i,
	input  wire logic [1:0]       main_enable_i,
	input  wire logic [1:0]       aux_enable_in_i,
	input  wire logic [1:0]       general_input_pin_i,
	input  wire logic             bus_strap_disable_i,
	input  wire hpc_sense_t [1:0] sense_i,
	input  wire logic [7:0]       addr_i,
	input  wire logic [7:0]       wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic [7:0]            rdata_o,
	output logic [1:0]            gate_drive_12v_on_o,
	output logic [1:0]            gate_drive_3v3_on_o,
	output logic [1:0]            aux_output_on_o,
	output logic [1:0]            fault_n_o,
	output logic [1:0]            power_good_out_o,
	output logic                  int_n_o,
	output logic                  por_busy_o
);

	typedef struct packed
	{
		logic [1:0]         stby_s1;
		logic [1:0]         stby_s2;
		logic [1:0]         mains_s1;
		logic [1:0]         mains_s2;
		logic [7:0]         pins_s1;
		logic [7:0]         pins_s2;
		logic [CNT_W-1:0]   por_cnt;
		logic               por_done;
		logic [7:0]         common;
		logic [7:0]         rdata;
		logic               int_flag;
		hpc_slot_t [1:0]    slot;
	} hpc_state_t;

	hpc_state_t state_reg;
	hpc_state_t state_next;

	logic              stby_ok;
	logic              standby;
	logic              bus_ok;
	logic              bus_ctrl;
	logic [1:0]        pin_main;
	logic [1:0]        pin_aux;
	logic [1:0]        general_input_pin;
	logic [1:0]        strap;

	assign stby_ok  = state_reg.stby_s2[0];
	assign standby  = ~state_reg.mains_s2[0];
	assign pin_main = state_reg.pins_s2[1:0];
	assign pin_aux  = state_reg.pins_s2[3:2];
	assign general_input_pin      = state_reg.pins_s2[5:4];
	assign strap    = state_reg.pins_s2[7:6];
	assign bus_ok   = state_reg.por_done & ~strap[0];                        // [RULE_04] [RULE_19]
	assign bus_ctrl = state_reg.common[CM_BUS_CTRL];

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [1:0] main_req;
		logic [1:0] aux_req;
		logic       wr_ok;
		logic       any_uv;
		main_req   = '0;
		aux_req    = '0;
		wr_ok      = wr_i & bus_ok;
		any_uv     = 1'b0;
		state_next = state_reg;

		state_next.stby_s1  = {1'b0, stby_valid_i};
		state_next.stby_s2  = state_reg.stby_s1;
		state_next.mains_s1 = {1'b0, mains_present_i};
		state_next.mains_s2 = state_reg.mains_s1;
		state_next.pins_s1  = {1'b0, bus_strap_disable_i, general_input_pin_i,
			aux_enable_in_i, main_enable_i};
		state_next.pins_s2  = state_reg.pins_s1;

		// power-on reset: counts valid standby, restarts on any dropout
		if (!stby_ok)
		begin
			state_next          = '0;                                        // [RULE_02] [RULE_03]
			state_next.stby_s1  = {1'b0, stby_valid_i};
			state_next.stby_s2  = state_reg.stby_s1;
		end
		else if (!state_reg.por_done)
		begin
			if (state_reg.por_cnt >= CNT_W'(POR_CNT - 1))
			begin
				state_next.por_done = 1'b1;                                  // [RULE_01]
			end
			else
			begin
				state_next.por_cnt = state_reg.por_cnt + CNT_W'(1);
			end
		end
		else
		begin
			// register read, one cycle latency; unmapped reads zero
			state_next.rdata = '0;
			if (rd_i && bus_ok)
			begin
				unique case (addr_i)
					REG_CTRL_A:  state_next.rdata = state_reg.slot[0].ctrl;
					REG_CTRL_B:  state_next.rdata = state_reg.slot[1].ctrl;
					REG_STAT_A:  state_next.rdata = {4'h0, state_reg.slot[0].fault}; // [RULE_11]
					REG_STAT_B:  state_next.rdata = {4'h0, state_reg.slot[1].fault};
					REG_COMMON:  state_next.rdata = {state_reg.common[7:5], standby,
						general_input_pin, state_reg.common[1:0]};
					default:     state_next.rdata = '0;
				endcase
			end
			if (wr_ok && addr_i == REG_COMMON)
			begin
				state_next.common[1:0] = wdata_i[1:0];                       // [RULE_10]
			end

			for (int s = 0; s < 2; s++)                                      // [RULE_22]
			begin
				logic [ST_W-1:0] set_f;
				logic [ST_W-1:0] clr_f;
				logic            ctrl_wr;
				set_f   = '0;
				clr_f   = '0;
				ctrl_wr = 1'b0;
				// power-control writes honoured only in bus control mode
				if (wr_ok && bus_ctrl && addr_i == (s == 0 ? REG_CTRL_A : REG_CTRL_B))
				begin
					ctrl_wr = 1'b1;                                          // [RULE_09]
					state_next.slot[s].ctrl = {6'h00, wdata_i[1:0]};
					if (wdata_i[1:0] != state_reg.slot[s].ctrl[1:0])
					begin
						clr_f = '1;                                          // [RULE_21]
					end
				end
				if (wr_ok && addr_i == (s == 0 ? REG_STAT_A : REG_STAT_B))
				begin
					clr_f = clr_f | wdata_i[ST_W-1:0];                       // [RULE_20]
				end
				main_req[s] = bus_ctrl ? state_reg.slot[s].ctrl[CTL_MAIN_BIT] : pin_main[s];
				aux_req[s]  = bus_ctrl ? state_reg.slot[s].ctrl[CTL_AUX_BIT] : pin_aux[s];
				state_next.slot[s].main_en_q = main_req[s];
				state_next.slot[s].aux_en_q  = aux_req[s];

				// main path
				unique case (state_reg.slot[s].main_st)
					HPC_OFF:
					begin
						if (main_req[s] && !standby && !sense_i[s].uv_main) // [RULE_18]
						begin
							state_next.slot[s].main_st = HPC_ON;
						end
					end
					HPC_ON, HPC_REG:
					begin
						if (!main_req[s])
						begin
							state_next.slot[s].main_st = HPC_OFF;
						end
						else if (sense_i[s].woc_main || sense_i[s].ot)
						begin
							state_next.slot[s].main_st = HPC_TRIPPED;        // [RULE_07]
							set_f[ST_OC_MAIN]          = sense_i[s].woc_main;
						end
						else if (standby || sense_i[s].uv_main)
						begin
							state_next.slot[s].main_st = HPC_TRIPPED;        // [RULE_13] [RULE_15]
						end
						else if (sense_i[s].oc_main)
						begin
							state_next.slot[s].main_st = HPC_REG;
							state_next.slot[s].main_dur = state_reg.slot[s].main_dur
								+ CNT_W'(1);
							if (state_reg.slot[s].main_dur >= CNT_W'(DUR_CNT - 1))
							begin
								state_next.slot[s].main_st = HPC_TRIPPED;    // [RULE_08]
								set_f[ST_OC_MAIN]          = 1'b1;
							end
						end
						else
						begin
							state_next.slot[s].main_st  = HPC_ON;
							state_next.slot[s].main_dur = '0;
						end
					end
					HPC_TRIPPED:
					begin
						state_next.slot[s].main_dur = '0;
						if (!main_req[s] || ctrl_wr)
						begin
							state_next.slot[s].main_st = HPC_OFF;            // [RULE_06]
						end
					end
				endcase

				// aux path keeps running in standby
				if (!aux_req[s] || (ctrl_wr && clr_f != '0))
				begin
					state_next.slot[s].aux_on      = 1'b0;                   // [RULE_14]
					state_next.slot[s].aux_tripped = 1'b0;
					state_next.slot[s].aux_dur     = '0;
				end
				else if (!state_reg.slot[s].aux_tripped)
				begin
					state_next.slot[s].aux_on = 1'b1;                        // [RULE_12]
					if (sense_i[s].oc_aux)
					begin
						state_next.slot[s].aux_dur = state_reg.slot[s].aux_dur + CNT_W'(1);
						if (state_reg.slot[s].aux_dur >= CNT_W'(DUR_CNT - 1))
						begin
							state_next.slot[s].aux_on      = 1'b0;           // [RULE_08]
							state_next.slot[s].aux_tripped = 1'b1;
							set_f[ST_OC_AUX]               = 1'b1;
						end
					end
					else
					begin
						state_next.slot[s].aux_dur = '0;
					end
				end

				set_f[ST_OT] = sense_i[s].ot;
				// losing the mains with main still requested counts as undervoltage
				set_f[ST_UV] = (sense_i[s].uv_main | standby) & main_req[s]; // [RULE_15]
				// a fault raised in the clearing cycle survives
				state_next.slot[s].fault = (state_reg.slot[s].fault & ~clr_f) | set_f;
				if (!main_req[s] && !aux_req[s] && !bus_ctrl)
				begin
					state_next.slot[s].fault = '0;                           // [RULE_06]
				end
				any_uv = any_uv | set_f[ST_UV];
			end

			if (any_uv && state_reg.common[CM_INT_EN])
			begin
				state_next.int_flag = 1'b1;                                  // [RULE_16]
			end
			else if ((state_reg.slot[0].fault | state_reg.slot[1].fault) == '0)
			begin
				state_next.int_flag = 1'b0;                                  // [RULE_20]
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_slot
			logic main_on;
			assign main_on = state_reg.por_done &&
				(state_reg.slot[g].main_st == HPC_ON || state_reg.slot[g].main_st == HPC_REG);
			assign gate_drive_12v_on_o[g] = main_on;                         // [RULE_17] [RULE_04]
			assign gate_drive_3v3_on_o[g] = main_on;                         // [RULE_17]
			assign aux_output_on_o[g]     = state_reg.por_done & state_reg.slot[g].aux_on;
			assign fault_n_o[g]           = ~(state_reg.slot[g].fault != '0);  // [RULE_05]
			assign power_good_out_o[g]    = main_on & sense_i[g].out_ok;     // [RULE_18]
		end
	endgenerate

	assign rdata_o    = state_reg.rdata;
	assign int_n_o    = ~state_reg.int_flag;
	assign por_busy_o = ~state_reg.por_done;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic main_req_q0;
	assign main_req_q0 = bus_ctrl ? state_reg.slot[0].ctrl[CTL_MAIN_BIT] : pin_main[0];

	sequence main_running_s(int s);
		state_reg.slot[s].main_st == HPC_ON || state_reg.slot[s].main_st == HPC_REG;
	endsequence

	por_outputs_off_a : assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE_04]
		!state_reg.por_done |-> (gate_drive_12v_on_o == 2'b00 && aux_output_on_o == 2'b00))
		else $error("output on during power-on reset");

	por_length_a : assert property (@(posedge ref_clk_i) disable iff (srst_i)    // [RULE_01]
		$rose(state_reg.por_done) |-> state_reg.por_cnt == CNT_W'(POR_CNT - 1))
		else $error("power-on reset ended at wrong count");

	por_restart_a : assert property (@(posedge ref_clk_i) disable iff (srst_i)   // [RULE_03]
		!stby_ok |=> !state_reg.por_done && state_reg.por_cnt == '0)
		else $error("power-on reset not restarted");

	woc_trip_a : assert property (@(posedge ref_clk_i) disable iff (srst_i)      // [RULE_07]
		(main_running_s(0) and sense_i[0].woc_main && main_req_q0 && state_reg.por_done
			&& stby_ok)
		|=> state_reg.slot[0].main_st == HPC_TRIPPED)
		else $error("severe overcurrent did not trip slot a");

	fault_pin_a : assert property (@(posedge ref_clk_i) disable iff (srst_i)     // [RULE_05]
		state_reg.slot[1].fault[ST_OC_MAIN] |-> !fault_n_o[1])
		else $error("fault pin not driven for latched fault");

	trip_off_a : assert property (@(posedge ref_clk_i) disable iff (srst_i)      // [RULE_08]
		state_reg.slot[0].main_st == HPC_TRIPPED |-> !gate_drive_12v_on_o[0])
		else $error("tripped slot still drives gate");

	bus_block_a : assert property (@(posedge ref_clk_i) disable iff (srst_i)     // [RULE_19]
		(rd_i && !bus_ok) |=> rdata_o == 8'h00)
		else $error("bus answered while inactive");

	pg_gate_a : assert property (@(posedge ref_clk_i) disable iff (srst_i)       // [RULE_18]
		power_good_out_o[0] |-> (sense_i[0].out_ok && gate_drive_3v3_on_o[0]))
		else $error("power-good without output in range");

endmodule : hpc_top

// ==== verif/hpc_slot_model.sv ====
// far side model: card loads and input supplies behind both slots
`timescale 1ns/1ps
module hpc_slot_model
	import hpc_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic [1:0]  gate_on_i,
	input  wire logic [1:0]  oc_cmd_i,
	input  wire logic [1:0]  woc_cmd_i,
	input  wire logic [1:0]  uv_cmd_i,
	output hpc_sense_t [1:0] sense_o
);
	logic [1:0] ramp_reg;

	// output settles one cycle after the gate turns on
	always_ff @(posedge ref_clk_i)
	begin
		ramp_reg <= gate_on_i;
	end

	// overcurrent only flows while the gate conducts, so a trip removes it
	always_comb
	begin
		for (int s = 0; s < 2; s++)
		begin
			sense_o[s].uv_main  = uv_cmd_i[s];
			sense_o[s].ot       = 1'b0;
			sense_o[s].oc_main  = oc_cmd_i[s] & gate_on_i[s];
			sense_o[s].woc_main = woc_cmd_i[s] & gate_on_i[s];
			sense_o[s].oc_aux   = 1'b0;
			sense_o[s].out_ok   = ramp_reg[s] & gate_on_i[s];
		end
	end
endmodule : hpc_slot_model

// ==== verif/tb_top.sv ====
// self-checking testbench for the hot-plug power controller
`timescale 1ns/1ps
module tb_top;
	import hpc_pkg::*;
	logic             ref_clk_i, srst_i, stby_valid_i, mains_present_i;
	logic             bus_strap_disable_i, wr_i, rd_i, rd_d, int_n_o, por_busy_o;
	logic [1:0]       main_enable_i, aux_enable_in_i, general_input_pin_i, g;
	logic [1:0]       oc_cmd, woc_cmd, uv_cmd, g12_o, g3_o, aux_o, fault_n_o, pg_o;
	logic [7:0]       addr_i, wdata_i, rdata_o, exp_v;
	hpc_sense_t [1:0] sense_i;
	logic [7:0]       exp_q[$];
	int               fail_count, n_checks, seed;

	hpc_top #(.POR_CNT(8), .DUR_CNT(16)) i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.stby_valid_i(stby_valid_i), .mains_present_i(mains_present_i),
		.main_enable_i(main_enable_i), .aux_enable_in_i(aux_enable_in_i),
		.general_input_pin_i(general_input_pin_i), .bus_strap_disable_i(bus_strap_disable_i),
		.sense_i(sense_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .gate_drive_12v_on_o(g12_o), .gate_drive_3v3_on_o(g3_o),
		.aux_output_on_o(aux_o), .fault_n_o(fault_n_o), .power_good_out_o(pg_o),
		.int_n_o(int_n_o), .por_busy_o(por_busy_o));

	hpc_slot_model i_load (.ref_clk_i(ref_clk_i), .gate_on_i(g3_o), .oc_cmd_i(oc_cmd),
		.woc_cmd_i(woc_cmd), .uv_cmd_i(uv_cmd), .sense_o(sense_i));

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] expv);
		n_checks++;
		if (seen !== expv)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask : settle

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
	endtask : bus_wr

	// expected read data is queued here and compared by the monitor below
	task automatic bus_rd(input logic [7:0] a, input logic [7:0] expv);
		@(posedge ref_clk_i);
		exp_q.push_back(expv);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
	endtask : bus_rd

	always @(posedge ref_clk_i) rd_d <= rd_i;

	always @(negedge ref_clk_i)
	begin
		if (rd_d === 1'b1 && exp_q.size() > 0)
		begin
			exp_v = exp_q.pop_front();
			check(rdata_o, exp_v);
		end
	end

	initial
	begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	initial
	begin
		#2_000_000;
		fail_count++;
		final_report();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		seed = 32'h9030a636;
		{srst_i, stby_valid_i, mains_present_i} = 3'b111;
		{bus_strap_disable_i, wr_i, rd_i} = 3'h0;
		{main_enable_i, aux_enable_in_i, oc_cmd, woc_cmd, uv_cmd} = 10'h000;
		{addr_i, wdata_i} = 16'h0000;
		g = 2'($random(seed));
		general_input_pin_i = g;
		fail_count = 0;
		n_checks = 0;
		repeat (20) @(posedge ref_clk_i);
		srst_i        <= 1'b0;
		main_enable_i <= 2'b01;
		bus_rd(REG_COMMON, 8'h00);
		settle(3);
		check({7'h0, por_busy_o}, 8'h01);
		check({6'h0, g3_o}, 8'h00);
		settle(10);
		check({7'h0, por_busy_o}, 8'h00);
		check({4'h0, g12_o, g3_o}, 8'h05);
		check({6'h0, pg_o}, 8'h01);
		// severe overcurrent trips at once, only slot a
		woc_cmd <= 2'b01;
		settle(3);
		check({4'h0, g3_o, fault_n_o}, 8'h02);
		bus_rd(REG_STAT_A, 8'h01);
		bus_rd(REG_STAT_B, 8'h00);
		woc_cmd       <= 2'b00;
		main_enable_i <= 2'b00; // pin control only
		settle(5);
		check({6'h0, fault_n_o}, 8'h03);
		// duration timer on slot b
		main_enable_i <= 2'b10;
		settle(5);
		oc_cmd <= 2'b10;
		settle(8);
		check({6'h0, g3_o}, 8'h02);
		settle(20);
		check({4'h0, g3_o, fault_n_o}, 8'h01);
		oc_cmd        <= 2'b00;
		// aux independent of main, standby entered with main still on
		aux_enable_in_i <= 2'b11;
		main_enable_i   <= 2'b01;
		settle(5);
		check({6'h0, aux_o}, 8'h03);
		mains_present_i <= 1'b0;
		settle(5);
		check({6'h0, aux_o}, 8'h03);
		check({7'h0, fault_n_o[0]}, 8'h00);
		bus_rd(REG_COMMON, {3'b000, 1'b1, g, 2'b00});
		mains_present_i <= 1'b1;
		main_enable_i   <= 2'b00;
		aux_enable_in_i <= 2'b00;
		g = 2'($random(seed));
		general_input_pin_i <= g;
		settle(5);
		// pin mode: power writes refused, others accepted
		bus_wr(REG_CTRL_A, 8'h01);
		settle(3);
		check({6'h0, g3_o}, 8'h00);
		bus_wr(REG_COMMON, 8'h01);
		bus_rd(REG_COMMON, {4'h0, g, 2'b01});
		bus_rd(8'h20, 8'h00);
		// bus control with interrupt on undervoltage
		bus_wr(REG_COMMON, 8'h03);
		bus_wr(REG_CTRL_A, 8'h01);
		settle(3);
		check({6'h0, g3_o}, 8'h01);
		uv_cmd <= 2'b01;
		settle(4);
		check({6'h0, int_n_o, fault_n_o[0]}, 8'h00);
		uv_cmd <= 2'b00;
		bus_wr(REG_STAT_A, 8'h0f);
		settle(2);
		check({7'h0, int_n_o}, 8'h01);
		// latch a fresh fault so the enable change has something to clear
		uv_cmd <= 2'b01;
		settle(2);
		check({7'h0, fault_n_o[0]}, 8'h00);
		uv_cmd <= 2'b00;
		bus_wr(REG_CTRL_A, 8'h00);
		settle(2);
		check({7'h0, fault_n_o[0]}, 8'h01);
		// strapped off: port inactive
		bus_strap_disable_i <= 1'b1;
		settle(4);
		bus_rd(REG_COMMON, 8'h00);
		bus_strap_disable_i <= 1'b0;
		// standby dropout starts a fresh power-on reset
		stby_valid_i <= 1'b0;
		settle(4);
		check({7'h0, por_busy_o}, 8'h01);
		stby_valid_i <= 1'b1;
		settle(20);
		bus_rd(REG_COMMON, {4'h0, g, 2'b00});
		bus_rd(REG_CTRL_A, 8'h00);
		settle(3);
		final_report();
	end
endmodule : tb_top
